//--- logic/aas_addsub.sv
`timescale 1ns/1ps
`default_nettype none
module aas_addsub
  import aas_pkg::*;
(
  aas_alu_if.alu io
);

  logic       is_sub;
  logic       c0;
  logic [7:0] bx;
  logic [8:0] full;
  logic [4:0] nib;

  // Subtract as a plus inverted b plus one; borrows are inverted carries
  always_comb begin
    is_sub = (io.op == AAS_OP_SUB);
    c0     = is_sub | ((io.op == AAS_OP_ADC) & io.cin);
    bx     = is_sub ? ~io.b : io.b;
    full   = {1'b0, io.a} + {1'b0, bx} + {8'h00, c0};
    nib    = {1'b0, io.a[3:0]} + {1'b0, bx[3:0]} + {4'h0, c0};
    io.res = full[7:0];
    io.flags = 8'h00;
    io.flags[FLG_NEG]   = full[7];
    io.flags[FLG_ZERO]  = (full[7:0] == 8'h00);
    io.flags[FLG_NIB]   = is_sub ? ~nib[4] : nib[4];
    io.flags[FLG_OVF]   = (io.a[7] == bx[7]) && (full[7] != io.a[7]);
    io.flags[FLG_SUB]   = is_sub;
    io.flags[FLG_CARRY] = is_sub ? ~full[8] : full[8];
  end

endmodule // aas_addsub
`default_nettype wire

//--- logic/aas_alu_if.sv
`timescale 1ns/1ps
`default_nettype none
interface aas_alu_if;
  import aas_pkg::*;
  logic    [7:0] a;
  logic    [7:0] b;
  logic          cin;
  aas_op_t       op;
  logic    [7:0] res;
  logic    [7:0] flags;
  modport core (output a, output b, output cin, output op, input res, input flags);
  modport alu  (input a, input b, input cin, input op, output res, output flags);
endinterface // aas_alu_if
`default_nettype wire

//--- logic/aas_core.sv
// Notes on behaviour
// - Register field: 111 accumulator, 000-101 select B, C, D, E, H, L.
// - Pattern 10000 plus register field adds register into accumulator.
// - Opcode C6 adds literal byte; two machine cycles, seven states.
// - Opcode 86 adds byte addressed by pointer_pair; seven states.
// - DD 86 d adds byte at first_index_reg plus signed d; 19 states.
// - FD 86 d works the same using second_index_reg.
// - Negative and zero flags follow the result of every operation.
// - Add forms set nibble carry on carry out of bit 3.
// - Overflow flag set on overflow, cleared otherwise, all three operations.
// - Add forms: carry flag is carry out of bit 7, subtract flag cleared.
// - Add-with-carry adds operand plus carry_in_bit into accumulator.
// - Add-with-carry decodes 10001 r, CE n, 8E, DD/FD 8E d; register four states.
// - Subtract decodes 10010 r, D6 n, 96, DD/FD 96 d; accumulator minus operand.
// - Subtract sets nibble flag on borrow from bit 4.
// - Subtract sets subtract flag; carry flag shows borrow.
`timescale 1ns/1ps
`default_nettype none
module aas_core
  import aas_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic      [15:0] mem_addr,
  output logic             mem_rd,
  input  wire logic [7:0]  mem_rdata,
  output logic      [7:0]  acc,
  output logic      [7:0]  cond_word,
  output logic             busy
);

  aas_state_t  state_q;
  aas_state_t  state_d;
  aas_form_t   form_q;
  aas_op_t     op_q;
  logic [7:0]  gpr_q [0:7];
  logic [15:0] ix_q;
  logic [15:0] iy_q;
  logic [15:0] pc_q;
  logic [15:0] rd_addr_q;
  logic [15:0] eff_addr;
  logic [7:0]  opc_q;
  logic [7:0]  disp_q;
  logic        idx_sel_q;
  logic        run_q;
  logic        step_q;
  logic        bad_q;
  logic        busy_q;
  logic [4:0]  cyc_q;
  logic [31:0] reg_rdata_q;
  logic [15:0] mem_addr_q;
  logic        mem_rd_q;
  logic [2:0]  len;
  logic [2:0]  tcnt;
  logic        last;
  logic        start;
  logic        is_pfx;
  logic        is_reg;
  logic        is_imm;
  logic        is_ptr;
  logic        fetch_last;
  logic        ends;
  logic        exec;
  logic        bad_evt;
  logic        issue;
  logic        idle_wr;
  logic        gpr_hit;

  aas_alu_if alu_bus ();

  aas_addsub u_alu (
    .io (alu_bus)
  );

  aas_tstate_timer u_timer (
    .clk   (clk),
    .rst   (rst),
    .hold  (state_q == ST_IDLE),
    .len   (len),
    .count (tcnt),
    .last  (last)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  // Opcode decode
  // ADD, ADC and SUB patterns, index prefixes
  always_comb begin
    is_pfx = (opc_q == OPC_PFX_FIRST) || (opc_q == OPC_PFX_SECOND);
    is_reg = ((opc_q[7:3] == PAT_ADD_REG) || (opc_q[7:3] == PAT_ADC_REG) ||
              (opc_q[7:3] == PAT_SUB_REG)) && (opc_q[2:0] != SLOT_FLAGS);
    is_imm = (opc_q == OPC_ADD_IMM) || (opc_q == OPC_ADC_IMM) || (opc_q == OPC_SUB_IMM);
    is_ptr = (opc_q == OPC_ADD_PTR) || (opc_q == OPC_ADC_PTR) || (opc_q == OPC_SUB_PTR);
  end

  always_comb begin
    case (state_q)
      ST_DISP, ST_READ: len = LEN_MEM;
      ST_CALC:          len = LEN_CALC;
      default:          len = LEN_FETCH;
    endcase
  end

  assign start      = run_q | step_q;
  assign fetch_last = (state_q == ST_FETCH) && last;
  assign issue      = (state_q != ST_IDLE) && (state_q != ST_CALC) && (tcnt == 3'h0);
  assign exec    = (fetch_last && is_reg) || ((state_q == ST_READ) && last);
  assign bad_evt = (fetch_last && !is_pfx && !is_reg && !is_imm && !is_ptr) ||
                   ((state_q == ST_FETCH2) && last && !is_ptr);
  assign ends    = exec || bad_evt;
  assign eff_addr = (idx_sel_q ? iy_q : ix_q) + {{8{disp_q[7]}}, disp_q};

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start) begin
          state_d = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (last && is_pfx) begin
          state_d = ST_FETCH2;
        end else if (last && (is_imm || is_ptr)) begin
          state_d = ST_READ;
        end
      end
      ST_FETCH2: begin
        if (last && is_ptr) begin
          state_d = ST_DISP;
        end
      end
      ST_DISP: begin
        if (last) begin
          state_d = ST_CALC;
        end
      end
      ST_CALC: begin
        if (last) begin
          state_d = ST_READ;
        end
      end
      default: ;
    endcase
    if (ends) begin
      state_d = run_q ? ST_FETCH : ST_IDLE;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      busy_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      busy_q  <= (state_d != ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing

  // Operand source select into the adder
  // register field picks operand
  always_comb begin
    alu_bus.a   = gpr_q[REG_A];
    alu_bus.b   = (state_q == ST_READ) ? mem_rdata : gpr_q[opc_q[2:0]];
    alu_bus.cin = gpr_q[SLOT_FLAGS][FLG_CARRY];
    alu_bus.op  = (state_q == ST_FETCH) ? aas_op_t'(opc_q[4:3]) : op_q;
  end

  // Memory reads issue in the first state, data is back two states later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_rd_q   <= 1'b0;
      mem_addr_q <= RST_PC;
    end else begin
      mem_rd_q <= issue;
      if (issue) begin
        mem_addr_q <= (state_q == ST_READ) ? rd_addr_q : pc_q;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      opc_q  <= 8'h00;
      disp_q <= 8'h00;
    end else if (tcnt == T_DATA) begin
      if ((state_q == ST_FETCH) || (state_q == ST_FETCH2)) begin
        opc_q <= mem_rdata;
      end else if (state_q == ST_DISP) begin
        disp_q <= mem_rdata;
      end
    end
  end

  // Operand address, form and operation of the instruction under way
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_addr_q <= RST_PC;
      form_q    <= FORM_REG;
      op_q      <= AAS_OP_ADD;
      idx_sel_q <= 1'b0;
    end else if (fetch_last) begin
      op_q      <= aas_op_t'(opc_q[4:3]);
      idx_sel_q <= (opc_q == OPC_PFX_SECOND);
      if (is_imm) begin
        rd_addr_q <= pc_q;
        form_q    <= FORM_IMM;
      end else if (is_ptr) begin
        rd_addr_q <= {gpr_q[REG_H], gpr_q[REG_L]};
        form_q    <= FORM_PTR;
      end else begin
        form_q    <= FORM_REG;
      end
    end else if ((state_q == ST_FETCH2) && last) begin
      op_q   <= aas_op_t'(opc_q[4:3]);
      form_q <= FORM_IDX;
    end else if ((state_q == ST_CALC) && last) begin
      rd_addr_q <= eff_addr;
    end
  end

  // States spent in the current instruction
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cyc_q <= 5'h00;
    end else if ((state_d == ST_FETCH) && ((state_q == ST_IDLE) || ends)) begin
      cyc_q <= 5'h01;
    end else if (state_q != ST_IDLE) begin
      cyc_q <= cyc_q + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file and software port

  assign idle_wr = reg_wr && (state_q == ST_IDLE);
  assign gpr_hit = (reg_addr <= OFS_GPR_LAST) && (reg_addr[1:0] == 2'h0);

  // Register file writes only while idle so they never race the adder; control and status writes are taken while busy
  for (genvar gi = 0; gi < 8; gi++) begin : g_gpr
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        gpr_q[gi] <= RST_GPR;
      end else if (idle_wr && gpr_hit && (reg_addr[4:2] == 3'(gi))) begin
        gpr_q[gi] <= (3'(gi) == SLOT_FLAGS) ? (reg_wdata[7:0] & FLG_MASK) : reg_wdata[7:0];
      end else if (exec && (3'(gi) == REG_A)) begin
        gpr_q[gi] <= alu_bus.res;
      end else if (exec && (3'(gi) == SLOT_FLAGS)) begin
        gpr_q[gi] <= alu_bus.flags;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ix_q <= RST_IDX;
      iy_q <= RST_IDX;
      pc_q <= RST_PC;
    end else begin
      if (idle_wr && (reg_addr == OFS_IX)) begin
        ix_q <= reg_wdata[15:0];
      end
      if (idle_wr && (reg_addr == OFS_IY)) begin
        iy_q <= reg_wdata[15:0];
      end
      if (idle_wr && (reg_addr == OFS_PC)) begin
        pc_q <= reg_wdata[15:0];
      end else if ((issue && (state_q != ST_READ)) || (fetch_last && is_imm)) begin
        pc_q <= pc_q + 16'h0001;
      end
    end
  end

  // Step request survives a start in the same cycle: set wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_q  <= 1'b0;
      step_q <= 1'b0;
      bad_q  <= 1'b0;
    end else begin
      if (reg_wr && (reg_addr == OFS_CTRL)) begin
        run_q <= reg_wdata[CTRL_RUN];
      end
      if (reg_wr && (reg_addr == OFS_CTRL) && reg_wdata[CTRL_STEP]) begin
        step_q <= 1'b1;
      end else if ((state_q == ST_IDLE) && start) begin
        step_q <= 1'b0;
      end
      if (bad_evt) begin
        bad_q <= 1'b1;
      end else if (reg_wr && (reg_addr == OFS_STATUS) && reg_wdata[STAT_BAD]) begin
        bad_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      if (gpr_hit) begin
        reg_rdata_q <= {24'h00_0000, gpr_q[reg_addr[4:2]]};
      end else if (reg_addr == OFS_IX) begin
        reg_rdata_q <= {16'h0000, ix_q};
      end else if (reg_addr == OFS_IY) begin
        reg_rdata_q <= {16'h0000, iy_q};
      end else if (reg_addr == OFS_PC) begin
        reg_rdata_q <= {16'h0000, pc_q};
      end else if (reg_addr == OFS_CTRL) begin
        reg_rdata_q <= {30'h0000_0000, step_q, run_q};
      end else if (reg_addr == OFS_STATUS) begin
        reg_rdata_q <= {30'h0000_0000, bad_q, busy_q};
      end else begin
        reg_rdata_q <= 32'h0000_0000;
      end
    end
  end

  assign reg_rdata = reg_rdata_q;
  assign mem_addr  = mem_addr_q;
  assign mem_rd    = mem_rd_q;
  assign acc       = gpr_q[REG_A];
  assign cond_word = gpr_q[SLOT_FLAGS];
  assign busy      = busy_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic       chk_c0;
  logic [8:0] chk_sum;
  logic [8:0] chk_diff;
  logic [4:0] chk_nib;
  logic [9:0] chk_wide;
  logic       chk_ovf;

  // Independent reference arithmetic for the checks below
  always_comb begin
    chk_c0   = (alu_bus.op == AAS_OP_ADC) & alu_bus.cin;
    chk_sum  = {1'b0, alu_bus.a} + {1'b0, alu_bus.b} + {8'h00, chk_c0};
    chk_diff = {1'b0, alu_bus.a} - {1'b0, alu_bus.b};
    chk_nib  = {1'b0, alu_bus.a[3:0]} + {1'b0, alu_bus.b[3:0]} + {4'h0, chk_c0};
    chk_wide = (alu_bus.op == AAS_OP_SUB) ?
               ({alu_bus.a[7], alu_bus.a[7], alu_bus.a} - {alu_bus.b[7], alu_bus.b[7], alu_bus.b}) :
               ({alu_bus.a[7], alu_bus.a[7], alu_bus.a} + {alu_bus.b[7], alu_bus.b[7], alu_bus.b} +
                {9'h000, chk_c0});
    chk_ovf  = (chk_wide[8] != chk_wide[7]);
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_rd_issue;
    mem_rd_q ##1 !mem_rd_q;
  endsequence

  sequence s_ptr_read;
    (state_q == ST_READ) && (tcnt == 3'h0) && (form_q == FORM_PTR);
  endsequence

  property p_reg_len;
    exec && (state_q == ST_FETCH) |-> (cyc_q == 5'h04);
  endproperty
  a_reg_len: assert property (p_reg_len) else $error("register form not four states");

  property p_imm_len;
    exec && (form_q == FORM_IMM) && (state_q == ST_READ) |-> (cyc_q == 5'h07);
  endproperty
  a_imm_len: assert property (p_imm_len) else $error("immediate form not seven states");

  property p_ptr_read;
    s_ptr_read |=> (mem_addr_q == {gpr_q[REG_H], gpr_q[REG_L]}) ##0 s_rd_issue ##0 (cyc_q == 5'h07);
  endproperty
  a_ptr_read: assert property (p_ptr_read) else $error("pointer read wrong address or timing");

  property p_ix_read;
    (state_q == ST_READ) && (form_q == FORM_IDX) && !idx_sel_q |->
      (rd_addr_q == ix_q + {{8{disp_q[7]}}, disp_q}) && (cyc_q >= 5'h11) && (cyc_q <= 5'h13);
  endproperty
  a_ix_read: assert property (p_ix_read) else $error("first index address or timing wrong");

  property p_iy_read;
    (state_q == ST_READ) && (form_q == FORM_IDX) && idx_sel_q && (tcnt == 3'h0) |->
      (rd_addr_q == iy_q + {{8{disp_q[7]}}, disp_q}) ##1 (mem_addr_q == rd_addr_q);
  endproperty
  a_iy_read: assert property (p_iy_read) else $error("second index address wrong");

  property p_sign_zero;
    exec |=> (cond_word[FLG_ZERO] == (acc == 8'h00)) && (cond_word[FLG_NEG] == acc[7]);
  endproperty
  a_sign_zero: assert property (p_sign_zero) else $error("sign or zero flag wrong");

  property p_add_nib;
    exec && (alu_bus.op != AAS_OP_SUB) |=> cond_word[FLG_NIB] == $past(chk_nib[4]);
  endproperty
  a_add_nib: assert property (p_add_nib) else $error("half carry wrong on add");

  property p_ovf;
    exec |=> cond_word[FLG_OVF] == $past(chk_ovf);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag wrong");

  property p_add_carry;
    exec && (alu_bus.op != AAS_OP_SUB) |=> !cond_word[FLG_SUB] && (cond_word[FLG_CARRY] == $past(chk_sum[8]));
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("carry or subtract flag wrong on add");

  property p_adc_sum;
    exec && (alu_bus.op == AAS_OP_ADC) |=> acc == $past(chk_sum[7:0]);
  endproperty
  a_adc_sum: assert property (p_adc_sum) else $error("add with carry result wrong");

  property p_sub_res;
    exec && (alu_bus.op == AAS_OP_SUB) |=> acc == $past(chk_diff[7:0]);
  endproperty
  a_sub_res: assert property (p_sub_res) else $error("subtract result wrong");

  property p_sub_nib;
    exec && (alu_bus.op == AAS_OP_SUB) |=> cond_word[FLG_NIB] == $past(alu_bus.a[3:0] < alu_bus.b[3:0]);
  endproperty
  a_sub_nib: assert property (p_sub_nib) else $error("half borrow wrong on subtract");

  property p_sub_flags;
    exec && (alu_bus.op == AAS_OP_SUB) |=> cond_word[FLG_SUB] && (cond_word[FLG_CARRY] == $past(chk_diff[8]));
  endproperty
  a_sub_flags: assert property (p_sub_flags) else $error("subtract or borrow flag wrong");

endmodule // aas_core
`default_nettype wire

//--- logic/aas_pkg.sv
package aas_pkg;

  // Machine cycle lengths in clock cycles, one clock per state
  localparam logic [2:0] LEN_FETCH = 3'h4;
  localparam logic [2:0] LEN_MEM   = 3'h3;
  localparam logic [2:0] LEN_CALC  = 3'h5;
  // Cycle inside a read cycle where memory data is valid
  localparam logic [2:0] T_DATA    = 3'h2;

  // Opcodes and five-bit register-form patterns
  localparam logic [7:0] OPC_PFX_FIRST  = 8'hdd;
  localparam logic [7:0] OPC_PFX_SECOND = 8'hfd;
  localparam logic [7:0] OPC_ADD_IMM    = 8'hc6;
  localparam logic [7:0] OPC_ADC_IMM    = 8'hce;
  localparam logic [7:0] OPC_SUB_IMM    = 8'hd6;
  localparam logic [7:0] OPC_ADD_PTR    = 8'h86;
  localparam logic [7:0] OPC_ADC_PTR    = 8'h8e;
  localparam logic [7:0] OPC_SUB_PTR    = 8'h96;
  localparam logic [4:0] PAT_ADD_REG    = 5'h10;
  localparam logic [4:0] PAT_ADC_REG    = 5'h11;
  localparam logic [4:0] PAT_SUB_REG    = 5'h12;

  // Register field codes; 110 is the memory operand
  localparam logic [2:0] REG_B      = 3'h0;
  localparam logic [2:0] REG_C      = 3'h1;
  localparam logic [2:0] REG_D      = 3'h2;
  localparam logic [2:0] REG_E      = 3'h3;
  localparam logic [2:0] REG_H      = 3'h4;
  localparam logic [2:0] REG_L      = 3'h5;
  localparam logic [2:0] SLOT_FLAGS = 3'h6;
  localparam logic [2:0] REG_A      = 3'h7;

  // Condition word bit positions
  localparam int unsigned FLG_NEG   = 7;
  localparam int unsigned FLG_ZERO  = 6;
  localparam int unsigned FLG_NIB   = 4;
  localparam int unsigned FLG_OVF   = 2;
  localparam int unsigned FLG_SUB   = 1;
  localparam int unsigned FLG_CARRY = 0;
  localparam logic [7:0]  FLG_MASK  = 8'hd7;

  // Register map, byte addresses of 32-bit words
  localparam logic [7:0] OFS_GPR_LAST = 8'h1c;
  localparam logic [7:0] OFS_IX       = 8'h20;
  localparam logic [7:0] OFS_IY       = 8'h24;
  localparam logic [7:0] OFS_PC       = 8'h28;
  localparam logic [7:0] OFS_CTRL     = 8'h2c;
  localparam logic [7:0] OFS_STATUS   = 8'h30;
  localparam int unsigned CTRL_RUN    = 0;
  localparam int unsigned CTRL_STEP   = 1;
  localparam int unsigned STAT_BUSY   = 0;
  localparam int unsigned STAT_BAD    = 1;

  // Reset values
  localparam logic [7:0]  RST_GPR = 8'h00;
  localparam logic [15:0] RST_IDX = 16'h0000;
  localparam logic [15:0] RST_PC  = 16'h0000;

  typedef enum logic [1:0] {AAS_OP_ADD, AAS_OP_ADC, AAS_OP_SUB, AAS_OP_NONE} aas_op_t;
  typedef enum logic [1:0] {FORM_REG, FORM_IMM, FORM_PTR, FORM_IDX} aas_form_t;
  typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_FETCH2, ST_DISP, ST_CALC, ST_READ} aas_state_t;

endpackage

//--- logic/aas_tstate_timer.sv
`timescale 1ns/1ps
`default_nettype none
module aas_tstate_timer
  import aas_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       hold,
  input  wire logic [2:0] len,
  output logic      [2:0] count,
  output logic            last
);

  // Wraps on its own so back-to-back machine cycles need no restart
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 3'h0;
    end else if (hold || last) begin
      count <= 3'h0;
    end else begin
      count <= count + 3'h1;
    end
  end

  assign last = !hold && (count == (len - 3'h1));

endmodule // aas_tstate_timer
`default_nettype wire

//--- verification/aas_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module aas_mem_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_rd,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] mem [0:65535];

  // Outside the data cycle the bus flips every clock, so stale data never looks valid
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_rdata <= 8'h5a;
    end else if (mem_rd) begin
      mem_rdata <= mem[mem_addr];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // aas_mem_model
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import aas_pkg::*;
;
  logic        clk       = 1'b0;
  logic        rst       = 1'b1;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        rd_seen   = 1'b0;
  logic [31:0] reg_rdata;
  logic [15:0] mem_addr;
  logic        mem_rd;
  logic [7:0]  mem_rdata;
  logic [7:0]  acc;
  logic [7:0]  cond_word;
  logic        busy;
  int          num_errors = 0;
  int          n_checks   = 0;
  logic [31:0] seed       = 32'h2eedd386;
  logic [31:0] exp_q[$];
  string       nam_q[$];
  logic [7:0]  rg [8];

  always #50 clk = ~clk;

  aas_core uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_rdata(mem_rdata), .acc(acc), .cond_word(cond_word), .busy(busy));
  aas_mem_model mdl (.clk(clk), .rst(rst), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata));

  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic bus(logic w, logic r, logic [7:0] a, logic [31:0] d);
    reg_wr    <= w;
    reg_rd    <= r;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
  endtask

  task automatic rd(string nm, logic [7:0] a, logic [31:0] e);
    exp_q.push_back(e);
    nam_q.push_back(nm);
    bus(1'b0, 1'b1, a, 32'h0);
  endtask

  // Read data is checked in the cycle after the strobe; it holds until the next read
  always @(posedge clk) rd_seen <= reg_rd;
  always @(negedge clk) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) chk("queue", 32'h1, 32'h0);
      else chk(nam_q.pop_front(), exp_q.pop_front(), reg_rdata);
    end
  end

  ////////////////////////////////////////
  task automatic run_one(int i);
    int          op;
    int          form;
    int          cnt;
    logic [2:0]  r;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  n;
    logic [7:0]  opc;
    logic [7:0]  fl;
    logic [8:0]  s;
    logic [4:0]  nib;
    logic [15:0] base;
    logic [15:0] ea;
    logic [15:0] la;
    logic        cc;
    logic        v;
    op   = i % 3;
    form = (i / 3) % 5;
    r    = (i / 15 == 6) ? 3'h7 : 3'(i / 15);
    for (int k = 0; k < 8; k++) rg[k] = 8'(rnd());
    rg[REG_H] = rg[REG_H] | 8'h80;
    n    = 8'(rnd());
    base = 16'(rnd()) | 16'h8000;
    ea   = (form == 2) ? {rg[REG_H], rg[REG_L]} : ((form == 3) ? base : base ^ 16'h4000) + {{8{n[7]}}, n};
    a    = rg[REG_A];
    b    = (form == 0) ? rg[r] : (form == 1) ? n : 8'(rnd());
    if (form >= 2) mdl.mem[ea] = b;
    opc  = (form == 0) ? {PAT_ADD_REG + 5'(op), r} : ((form == 1) ? OPC_ADD_IMM : OPC_ADD_PTR) + 8'(op * 8);
    mdl.mem[16'h0100] = (form == 3) ? OPC_PFX_FIRST : (form == 4) ? OPC_PFX_SECOND : opc;
    mdl.mem[16'h0101] = (form >= 3) ? opc : n;
    mdl.mem[16'h0102] = n;
    cc   = (op == 1) && rg[SLOT_FLAGS][0];
    if (op == 2) begin
      s   = {1'b0, a} - {1'b0, b};
      nib = {4'h0, a[3:0] < b[3:0]} << 4;
      v   = (a[7] != b[7]) && (s[7] != a[7]);
    end else begin
      s   = {1'b0, a} + {1'b0, b} + {8'h0, cc};
      nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cc};
      v   = (a[7] == b[7]) && (s[7] != a[7]);
    end
    fl = {s[7], s[7:0] == 8'h00, 1'b0, nib[4], 1'b0, v, op == 2, s[8]};
    for (int k = 0; k < 8; k++) bus(1'b1, 1'b0, 8'(k * 4), {24'h0, rg[k]});
    bus(1'b1, 1'b0, OFS_IX, {16'h0, base});
    bus(1'b1, 1'b0, OFS_IY, {16'h0, base ^ 16'h4000});
    bus(1'b1, 1'b0, OFS_PC, 32'h100);
    bus(1'b1, 1'b0, OFS_CTRL, 32'h2);
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    cnt = 0;
    la  = 16'h0;
    for (int k = 0; k < 40 && !(cnt > 0 && busy === 1'b0); k++) begin
      @(negedge clk);
      if (busy === 1'b1) cnt++;
      if (mem_rd === 1'b1) la = mem_addr;
    end
    if (cnt == 0 || busy !== 1'b0) begin
      chk("timeout", 32'h0, 32'h1);
      give_verdict();
    end
    chk("acc_pin", {24'h0, s[7:0]}, {24'h0, acc});
    chk("flags_pin", {24'h0, fl}, {24'h0, cond_word});
    @(posedge clk);
    chk("busy_cycles", (form == 0) ? 4 : (form < 3) ? 7 : 19, cnt);
    if (form >= 2) chk("operand_addr", {16'h0, ea}, {16'h0, la});
    rd("acc", 8'h1c, {24'h0, s[7:0]});
    rd("flags", 8'h18, {24'h0, fl});
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    $display("test %0d op %0d form %0d done", i, op, form);
  endtask

  // Run mode carries on to a second instruction; busy writes and bad opcodes
  task automatic run_extra();
    logic [7:0] a;
    a = 8'(rnd());
    mdl.mem[16'h0100] = {PAT_ADD_REG, REG_A};
    mdl.mem[16'h0101] = {PAT_ADD_REG, REG_A};
    bus(1'b1, 1'b0, 8'h1c, {24'h0, a});
    bus(1'b1, 1'b0, OFS_PC, 32'h100);
    bus(1'b1, 1'b0, OFS_CTRL, 32'h1);
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    bus(1'b1, 1'b0, 8'h1c, {24'h0, ~a});
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    bus(1'b1, 1'b0, OFS_CTRL, 32'h0);
    repeat (5) bus(1'b0, 1'b0, 8'h00, 32'h0);
    chk("busy_after_run", 32'h0, {31'h0, busy});
    rd("acc_run", 8'h1c, {24'h0, a[5:0], 2'h0});
    rd("pc_run", OFS_PC, 32'h102);
    mdl.mem[16'h0102] = 8'h00;
    bus(1'b1, 1'b0, OFS_CTRL, 32'h2);
    repeat (6) bus(1'b0, 1'b0, 8'h00, 32'h0);
    rd("status_bad", OFS_STATUS, 32'h2);
    bus(1'b1, 1'b0, OFS_STATUS, 32'h2);
    rd("status_clear", OFS_STATUS, 32'h0);
    rd("pc_bad", OFS_PC, 32'h103);
    rd("ctrl", OFS_CTRL, 32'h0);
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    $display("test run_and_bad done");
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd("acc_reset", 8'h1c, 32'h0);
    rd("flags_reset", 8'h18, 32'h0);
    rd("unmapped", 8'h34, 32'h0);
    for (int i = 0; i < 105; i++) run_one(i);
    run_extra();
    repeat (3) @(posedge clk);
    give_verdict();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    chk("watchdog", 32'h0, 32'h1);
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
